// ==== inc/mcts_params.svh ====
// constants of the clock tree select block: offsets, fields, resets, divider counts
// Notes on behaviour
// - main clock: internal, crystal or crystal halved
// - system clock is main clock, or divided by four
// - sleep stops both oscillators regardless of bits
// - oscillator enables decoded from the two control bits
// - instruction cycle divides main by 6.5/12.5/2/4
// - adc sample clock is main over 25 or 50
// - conversion of N bits gets 2^N sample clocks, N clamped at 16
// - beeper clock: system/250, system/375 or crystal/8
// - doubler clock: main/200, main/100 or crystal/32
// - chopper low, system/500 or system/1000
// - timer and lcd clock is system/1000, or held low with the tick bit set
`ifndef MCTS_PARAMS_SVH
`define MCTS_PARAMS_SVH

// register indices; byte address is four times the index
`define MCTS_IDX_MAIN   6'h14
`define MCTS_IDX_PERI   6'h15
`define MCTS_IDX_STAT   6'h16
`define MCTS_MAIN_RST   8'h00
`define MCTS_PERI_RST   8'h00
`define MCTS_MAIN_MASK  8'hEF
`define MCTS_PERI_MASK  8'h4F

// main_clock_config fields
`define MCTS_B_SRC      0
`define MCTS_B_DIV4     1
`define MCTS_B_FAST     2
`define MCTS_B_HALVE    3
`define MCTS_B_TICK     5
`define MCTS_B_OSC_LO   6
`define MCTS_B_OSC_HI   7
// peripheral_clock_config fields
`define MCTS_B_PUMP     0
`define MCTS_B_BEEP     1
`define MCTS_B_CHOP_LO  2
`define MCTS_B_CHOP_HI  3
`define MCTS_B_DOUBLER  6

// divider periods, counted in source clock edges (two per source period)
`define MCTS_P_INSTR_00 12'h00D
`define MCTS_P_INSTR_01 12'h019
`define MCTS_P_INSTR_10 12'h004
`define MCTS_P_INSTR_11 12'h008
`define MCTS_P_ADC_0    12'h032
`define MCTS_P_ADC_1    12'h064
`define MCTS_P_BEEP_250 12'h1F4
`define MCTS_P_BEEP_375 12'h2EE
`define MCTS_P_BEEP_X8  12'h010
`define MCTS_P_PUMP_200 12'h190
`define MCTS_P_PUMP_100 12'h0C8
`define MCTS_P_PUMP_X32 12'h040
`define MCTS_P_DIV_500  12'h3E8
`define MCTS_P_DIV_1000 12'h7D0
`define MCTS_P_OFF      12'h000

// divider channels
`define MCTS_NCH        6
`define MCTS_CH_INSTR   0
`define MCTS_CH_ADC     1
`define MCTS_CH_BEEP    2
`define MCTS_CH_PUMP    3
`define MCTS_CH_CHOP    4
`define MCTS_CH_TICK    5

`define MCTS_ADC_NMAX   5'h10
`define MCTS_RESP_OKAY  2'h0
`define MCTS_RESP_SLV   2'h2

`endif

// ==== inc/mcts_pkg.sv ====
// types of the clock tree select block
`include "mcts_params.svh"
package mcts_pkg;

   typedef enum logic [1:0] {
      MCTS_ADC_IDLE = 2'b01,
      MCTS_ADC_RUN  = 2'b10
   } mcts_adc_e;

   typedef struct packed {
      logic [11:0] cnt;
      logic [11:0] cur_per;
      logic [11:0] cur_high;
      logic        lvl;
      logic        rise;
   } mcts_div_s;

   typedef struct packed {
      logic        ick_meta;
      logic        ick_sync;
      logic        ick_prev;
      logic        eck_meta;
      logic        eck_sync;
      logic        eck_prev;
      logic        eck_half;
      logic        main_lvl;
      logic [1:0]  quarter;
      logic        sys_div;
      logic        sys_lvl;
      logic [7:0]  main_cfg;
      logic [7:0]  peri_cfg;
      logic        aw_got;
      logic [5:0]  aw_idx;
      logic        w_got;
      logic [7:0]  w_data;
      logic        w_lane0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic        int_osc_en;
      logic        xtal_osc_en;
      mcts_adc_e   adc_st;
      logic [16:0] adc_cnt;
      logic [16:0] adc_goal;
      logic        adc_done;
   } mcts_top_s;

endpackage : mcts_pkg

// ==== tb/mcts_top_props.sv ====
// bound checker for the clock tree select top: bus holds, oscillator gating, adc window
`timescale 1ns/10ps
`default_nettype none
module mcts_top_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        sleep_mode,
   input wire logic        adc_conv_start,
   input wire logic        int_osc_en,
   input wire logic        xtal_osc_en,
   input wire logic        adc_conv_busy,
   input wire logic        adc_conv_done,
   input wire logic        doubler_on,
   input wire logic        doubler_clk,
   input wire logic        cpu_cycle_clk
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sleep_stops_a: assert property (sleep_mode |=> !int_osc_en && !xtal_osc_en)
      else $error("oscillator left running in sleep");
   awake_osc_a: assert property (!sleep_mode ##1 !sleep_mode |-> int_osc_en || xtal_osc_en)
      else $error("both oscillators off outside sleep");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before rready");
   write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   adc_go_a: assert property (adc_conv_start && !adc_conv_busy |=> adc_conv_busy)
      else $error("conversion window did not open");
   done_end_a: assert property (adc_conv_done |-> !adc_conv_busy && $past(adc_conv_busy))
      else $error("done pulse not at end of window");
   done_pulse_a: assert property (adc_conv_done |=> !adc_conv_done)
      else $error("done pulse longer than one cycle");
   pump_off_a: assert property (!doubler_on [*3] |-> !doubler_clk)
      else $error("doubler clock runs while disabled");
   cycle_glitch_a: assert property ($rose(cpu_cycle_clk) |=> cpu_cycle_clk)
      else $error("instruction clock glitch");
endmodule : mcts_top_chk

bind mcts_top mcts_top_chk u_mcts_top_chk (
   .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .sleep_mode, .adc_conv_start, .int_osc_en, .xtal_osc_en, .adc_conv_busy,
   .adc_conv_done, .doubler_on, .doubler_clk, .cpu_cycle_clk
);
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the clock tree select block
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        internal_osc_clock = 1'b0, crystal_clock = 1'b0;
   logic        sleep_mode = 1'b0, adc_conv_start = 1'b0;
   logic [4:0]  adc_res_bits = 5'h00;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        int_osc_en, xtal_osc_en, main_clock, system_clock, cpu_cycle_clk;
   logic        adc_sample_freq, adc_conv_busy, adc_conv_done, beeper_clk;
   logic        doubler_clk, doubler_on, chopper_ctl, timer_lcd_clock;
   int          err_count = 0;
   int          n_checks = 0;
   int          iexp[4] = '{13, 25, 4, 8};
   wire logic [7:0] dv = {system_clock, main_clock, timer_lcd_clock, chopper_ctl,
                          doubler_clk, beeper_clk, adc_sample_freq, cpu_cycle_clk};
   wire logic [2:0] rv = {system_clock, main_clock, 1'b0};

   always #4 aclk = ~aclk;
   // oscillators run far faster than real parts so the long dividers finish quickly
   always #24 internal_osc_clock = ~internal_osc_clock;
   always #40 crystal_clock = ~crystal_clock;

   mcts_top u_mcts_top (
      .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .internal_osc_clock, .crystal_clock, .sleep_mode, .adc_conv_start, .adc_res_bits,
      .int_osc_en, .xtal_osc_en, .main_clock, .system_clock, .cpu_cycle_clk,
      .adc_sample_freq, .adc_conv_busy, .adc_conv_done, .beeper_clk, .doubler_clk,
      .doubler_on, .chopper_ctl, .timer_lcd_clock
   );

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
      end
   endtask : chk

   // handshakes are judged at the falling edge, where ready has settled for the next rise
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ah, wh, bh;
      logic [1:0] rs;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = s_axi_awvalid & s_axi_awready;
         wh = s_axi_wvalid & s_axi_wready;
         bh = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (ah)
            s_axi_awvalid <= 1'b0;
         if (wh)
            s_axi_wvalid <= 1'b0;
      end while (!bh);
      s_axi_bready <= 1'b0;
      chk("write response", {30'h0, er}, {30'h0, rs});
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ah, rh;
      logic [1:0] rs;
      logic [31:0] d;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ah = s_axi_arvalid & s_axi_arready;
         rh = s_axi_rvalid;
         rs = s_axi_rresp;
         d = s_axi_rdata;
         @(posedge aclk);
         if (ah)
            s_axi_arvalid <= 1'b0;
      end while (!rh);
      s_axi_rready <= 1'b0;
      chk("read data", ed, d);
      chk("read response", {30'h0, er}, {30'h0, rs});
   endtask : axi_rd

   // one full period of derived clock ch, in aclk cycles (rf 0) or reference toggles
   task automatic meas(input string nm, input int ch, input int rf, input int ex);
      int k = 0;
      int n = 0;
      int t = 0;
      logic p, r;
      #1;
      p = dv[ch];
      r = rv[rf];
      while (k < 2 && t < 30000) begin
         @(posedge aclk);
         #1;
         if (k == 1)
            n += (rf == 0) ? 1 : int'(rv[rf] != r);
         if (dv[ch] && !p)
            k++;
         p = dv[ch];
         r = rv[rf];
         t++;
      end
      chk(nm, ex, n);
   endtask : meas

   task automatic quiet(input string nm, input logic [7:0] mask, input int cyc);
      logic h = 1'b0;
      repeat (cyc) begin
         @(posedge aclk);
         #1;
         h |= |(dv & mask);
      end
      chk(nm, 0, h);
   endtask : quiet

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   initial begin
      int cnt, t;
      logic p;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(8'h50, 32'h00000000, 2'h0);
      axi_rd(8'h54, 32'h00000000, 2'h0);
      chk("int_osc_en", 1, int_osc_en);
      chk("xtal_osc_en", 1, xtal_osc_en);
      quiet("idle doubler and chopper", 8'h18, 3000);
      meas("main internal", 6, 0, 6);
      meas("timer tick", 5, 2, 2000);
      for (int i = 0; i < 4; i++) begin
         axi_wr(8'h50, {24'h0, i[1:0], 6'h20}, 2'h0);
         repeat (2) @(posedge aclk);
         #1;
         chk("int_osc_en", i != 2, int_osc_en);
         chk("xtal_osc_en", i[0] == 1'b0, xtal_osc_en);
         @(posedge aclk);
         sleep_mode <= 1'b1;
         repeat (2) @(posedge aclk);
         #1;
         chk("sleep oscillators", 0, {int_osc_en, xtal_osc_en});
         @(posedge aclk);
         sleep_mode <= 1'b0;
      end
      // bit 4 is reserved and reads back zero
      axi_wr(8'h50, 32'h000000FF, 2'h0);
      axi_rd(8'h50, 32'h000000EF, 2'h0);
      axi_wr(8'h60, 32'h00000001, 2'h2);
      axi_rd(8'h60, 32'h00000000, 2'h2);
      for (int j = 0; j < 4; j++) begin
         axi_wr(8'h50, {26'h0, 3'h4, j[1:0], 1'b0}, 2'h0);
         meas("instruction cycle", 0, 1, iexp[j]);
         meas("system clock", 7, 1, j[0] ? 8 : 2);
         meas("adc sample clock", 1, 1, j[0] ? 100 : 50);
      end
      axi_wr(8'h50, 32'h00000020, 2'h0);
      axi_wr(8'h54, 32'h00000040, 2'h0);
      meas("beeper", 2, 2, 500);
      meas("doubler", 3, 1, 400);
      axi_wr(8'h54, 32'h00000043, 2'h0);
      meas("beeper", 2, 2, 750);
      meas("doubler", 3, 1, 200);
      axi_wr(8'h50, 32'h00000021, 2'h0);
      meas("main crystal", 6, 0, 10);
      meas("beeper", 2, 1, 16);
      meas("doubler", 3, 1, 64);
      axi_wr(8'h50, 32'h00000029, 2'h0);
      meas("main halved", 6, 0, 20);
      axi_wr(8'h50, 32'h00000020, 2'h0);
      axi_wr(8'h54, 32'h00000004, 2'h0);
      quiet("chopper and tick held", 8'h30, 3000);
      axi_wr(8'h54, 32'h00000008, 2'h0);
      meas("chopper", 4, 2, 1000);
      axi_wr(8'h54, 32'h0000000C, 2'h0);
      meas("chopper", 4, 2, 2000);
      for (int b = 1; b < 4; b += 2) begin
         @(posedge aclk);
         adc_res_bits <= b[4:0];
         adc_conv_start <= 1'b1;
         #1;
         p = adc_sample_freq;
         @(posedge aclk);
         adc_conv_start <= 1'b0;
         cnt = 0;
         t = 0;
         do begin
            @(posedge aclk);
            #1;
            if (adc_conv_busy && adc_sample_freq && !p)
               cnt++;
            p = adc_sample_freq;
            t++;
         end while (!adc_conv_done && t < 5000);
         chk("adc window rises", 1 << b, cnt);
      end
      give_verdict();
   end

   // whole run stays near 40k cycles; the limit is 95k
   initial begin
      #760000;
      err_count++;
      give_verdict();
   end
endmodule : tb
`default_nettype wire

// ==== verilog/mcts_div.sv ====
// glitch-free edge-counting divider for one derived clock
`timescale 1ns/10ps
`default_nettype none
`include "mcts_params.svh"
module mcts_div (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        src_edge,
   input  wire logic [11:0] period,
   input  wire logic [11:0] high_len,
   output logic             div_clk,
   output logic             div_rise
);
   mcts_pkg::mcts_div_s st;
   mcts_pkg::mcts_div_s next_st;

   always_comb begin
      next_st = st;
      next_st.rise = 1'b0;
      if (period == `MCTS_P_OFF) begin
         next_st.cnt = 12'h000;
         next_st.cur_per = `MCTS_P_OFF;
         next_st.cur_high = 12'h000;
         next_st.lvl = 1'b0;
      end else if (st.cur_per == `MCTS_P_OFF) begin
         // start from a low output: the next source edge opens a whole high phase
         next_st.cur_per = period;
         next_st.cur_high = high_len;
         next_st.cnt = period - 12'h001;
      end else if (src_edge) begin
         // a new nonzero period or duty is taken only at the wrap, never mid-pulse; period zero stops at once
         if (st.cnt >= st.cur_per - 12'h001) begin
            next_st.cnt = 12'h000;
            next_st.cur_per = period;
            next_st.cur_high = high_len;
         end else begin
            next_st.cnt = st.cnt + 12'h001;
         end
         next_st.lvl = (next_st.cnt < next_st.cur_high);
         next_st.rise = next_st.lvl & ~st.lvl;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign div_clk = st.lvl;
   assign div_rise = st.rise;

endmodule : mcts_div
`default_nettype wire

// ==== verilog/mcts_top.sv ====
// clock tree select: source choice, oscillator gating, derived clocks, register slave
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "mcts_params.svh"
module mcts_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // register bus
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // oscillator pins and cpu side
   input  wire logic        internal_osc_clock,
   input  wire logic        crystal_clock,
   input  wire logic        sleep_mode,
   input  wire logic        adc_conv_start,
   input  wire logic [4:0]  adc_res_bits,
   // outputs
   output logic             int_osc_en,
   output logic             xtal_osc_en,
   output logic             main_clock,
   output logic             system_clock,
   output logic             cpu_cycle_clk,
   output logic             adc_sample_freq,
   output logic             adc_conv_busy,
   output logic             adc_conv_done,
   output logic             beeper_clk,
   output logic             doubler_clk,
   output logic             doubler_on,
   output logic             chopper_ctl,
   output logic             timer_lcd_clock
);
   mcts_pkg::mcts_top_s st;
   mcts_pkg::mcts_top_s next_st;

   logic        ick_edge;
   logic        eck_edge;
   logic        eck_rise;
   logic        main_edge;
   logic        clk_edge;
   logic        src_sel_bit;
   logic        clk_div4_sel;
   logic        cycle_fast_sel;
   logic        ext_halve_sel;
   logic        tick_div_sel;
   logic        osc_ctl_lo;
   logic        osc_ctl_hi;
   logic        pump_rate_sel;
   logic        beeper_rate_sel;
   logic [1:0]  chopper_rate_sel;
   logic        doubler_sel;
   logic        ch_edge [`MCTS_NCH];
   logic [11:0] ch_per  [`MCTS_NCH];
   logic        ch_lvl  [`MCTS_NCH];
   logic        ch_rise [`MCTS_NCH];
   logic        wr_fire;
   logic        rd_fire;
   logic [5:0]  rd_idx;
   logic [4:0]  res_clamp;

   assign src_sel_bit      = st.main_cfg[`MCTS_B_SRC];
   assign clk_div4_sel     = st.main_cfg[`MCTS_B_DIV4];
   assign cycle_fast_sel   = st.main_cfg[`MCTS_B_FAST];
   assign ext_halve_sel    = st.main_cfg[`MCTS_B_HALVE];
   assign tick_div_sel     = st.main_cfg[`MCTS_B_TICK];
   assign osc_ctl_lo       = st.main_cfg[`MCTS_B_OSC_LO];
   assign osc_ctl_hi       = st.main_cfg[`MCTS_B_OSC_HI];
   assign pump_rate_sel    = st.peri_cfg[`MCTS_B_PUMP];
   assign beeper_rate_sel  = st.peri_cfg[`MCTS_B_BEEP];
   assign chopper_rate_sel = {st.peri_cfg[`MCTS_B_CHOP_HI], st.peri_cfg[`MCTS_B_CHOP_LO]};
   assign doubler_sel      = st.peri_cfg[`MCTS_B_DOUBLER];

   // edges are seen only after the synchronised copy, never the meta stage
   assign ick_edge = st.ick_sync ^ st.ick_prev;
   assign eck_edge = st.eck_sync ^ st.eck_prev;
   assign eck_rise = st.eck_sync & ~st.eck_prev;

   // every main clock edge; the halved crystal changes once per crystal rise
   always_comb begin
      if (!src_sel_bit) begin
         main_edge = ick_edge;
      end else if (!ext_halve_sel) begin
         main_edge = eck_edge;
      end else begin
         main_edge = eck_rise;
      end
   end

   // system clock edge: one per main edge, or one per four main edges
   assign clk_edge = clk_div4_sel ? (main_edge & (st.quarter == 2'h3)) : main_edge;

   // divider periods per channel, in edges of the channel's source
   always_comb begin
      case ({cycle_fast_sel, clk_div4_sel})
         2'b00:   ch_per[`MCTS_CH_INSTR] = `MCTS_P_INSTR_00;
         2'b01:   ch_per[`MCTS_CH_INSTR] = `MCTS_P_INSTR_01;
         2'b10:   ch_per[`MCTS_CH_INSTR] = `MCTS_P_INSTR_10;
         default: ch_per[`MCTS_CH_INSTR] = `MCTS_P_INSTR_11;
      endcase
      ch_edge[`MCTS_CH_INSTR] = main_edge;

      ch_per[`MCTS_CH_ADC] = clk_div4_sel ? `MCTS_P_ADC_1 : `MCTS_P_ADC_0;
      ch_edge[`MCTS_CH_ADC] = main_edge;

      // a source swap takes effect on the new source's next edges; the pulse
      // in flight is finished by counts of the new source
      if (!beeper_rate_sel) begin
         ch_per[`MCTS_CH_BEEP] = `MCTS_P_BEEP_250;
         ch_edge[`MCTS_CH_BEEP] = clk_edge;
      end else if (!src_sel_bit) begin
         ch_per[`MCTS_CH_BEEP] = `MCTS_P_BEEP_375;
         ch_edge[`MCTS_CH_BEEP] = clk_edge;
      end else begin
         ch_per[`MCTS_CH_BEEP] = `MCTS_P_BEEP_X8;
         ch_edge[`MCTS_CH_BEEP] = eck_edge;
      end

      if (!doubler_sel) begin
         ch_per[`MCTS_CH_PUMP] = `MCTS_P_OFF;
         ch_edge[`MCTS_CH_PUMP] = 1'b0;
      end else if (src_sel_bit) begin
         ch_per[`MCTS_CH_PUMP] = `MCTS_P_PUMP_X32;
         ch_edge[`MCTS_CH_PUMP] = eck_edge;
      end else begin
         ch_per[`MCTS_CH_PUMP] = pump_rate_sel ? `MCTS_P_PUMP_100 : `MCTS_P_PUMP_200;
         ch_edge[`MCTS_CH_PUMP] = main_edge;
      end

      // code 01 has no defined output, so it is held low like 00
      case (chopper_rate_sel)
         2'b10:   ch_per[`MCTS_CH_CHOP] = `MCTS_P_DIV_500;
         2'b11:   ch_per[`MCTS_CH_CHOP] = `MCTS_P_DIV_1000;
         default: ch_per[`MCTS_CH_CHOP] = `MCTS_P_OFF;
      endcase
      ch_edge[`MCTS_CH_CHOP] = clk_edge;

      // the other tick option is not available and stops the tick clock
      ch_per[`MCTS_CH_TICK] = tick_div_sel ? `MCTS_P_OFF : `MCTS_P_DIV_1000;
      ch_edge[`MCTS_CH_TICK] = clk_edge;
   end

   genvar gi;
   generate
      for (gi = 0; gi < `MCTS_NCH; gi = gi + 1) begin : g_div
         mcts_div u_div (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .src_edge (ch_edge[gi]),
            .period   (ch_per[gi]),
            .high_len ((ch_per[gi] + 12'h001) >> 1),
            .div_clk  (ch_lvl[gi]),
            .div_rise (ch_rise[gi])
         );
      end
   endgenerate

   assign wr_fire = st.aw_got & st.w_got & ~st.bvalid;
   assign rd_fire = s_axi_arvalid & ~st.rvalid;
   assign rd_idx = s_axi_araddr[7:2];
   assign res_clamp = (adc_res_bits > `MCTS_ADC_NMAX) ? `MCTS_ADC_NMAX : adc_res_bits;

   always_comb begin
      next_st = st;
      next_st.adc_done = 1'b0;

      // two-stage synchronisers for the oscillator pins
      next_st.ick_meta = internal_osc_clock;
      next_st.ick_sync = st.ick_meta;
      next_st.ick_prev = st.ick_sync;
      next_st.eck_meta = crystal_clock;
      next_st.eck_sync = st.eck_meta;
      next_st.eck_prev = st.eck_sync;

      if (eck_rise) begin
         next_st.eck_half = ~st.eck_half;
      end
      if (!src_sel_bit) begin
         next_st.main_lvl = st.ick_sync;
      end else if (!ext_halve_sel) begin
         next_st.main_lvl = st.eck_sync;
      end else begin
         next_st.main_lvl = st.eck_half;
      end

      // divide-by-four: toggle after every fourth main edge
      if (main_edge) begin
         next_st.quarter = st.quarter + 2'h1;
      end
      if (clk_div4_sel && main_edge && (st.quarter == 2'h3)) begin
         next_st.sys_div = ~st.sys_div;
      end
      next_st.sys_lvl = clk_div4_sel ? st.sys_div : st.main_lvl;

      // oscillator gating; sleep overrides the control bits
      if (sleep_mode) begin
         next_st.int_osc_en = 1'b0;
         next_st.xtal_osc_en = 1'b0;
      end else begin
         next_st.int_osc_en = ~osc_ctl_hi | osc_ctl_lo;
         next_st.xtal_osc_en = ~osc_ctl_lo;
      end

      // conversion window: 2^N rising sample edges, N clamped at 16
      case (st.adc_st)
         mcts_pkg::MCTS_ADC_IDLE: begin
            if (adc_conv_start) begin
               next_st.adc_goal = 17'h00001 << res_clamp;
               next_st.adc_cnt = 17'h00000;
               next_st.adc_st = mcts_pkg::MCTS_ADC_RUN;
            end
         end
         mcts_pkg::MCTS_ADC_RUN: begin
            if (ch_rise[`MCTS_CH_ADC]) begin
               next_st.adc_cnt = st.adc_cnt + 17'h00001;
               if (st.adc_cnt + 17'h00001 == st.adc_goal) begin
                  next_st.adc_done = 1'b1;
                  next_st.adc_st = mcts_pkg::MCTS_ADC_IDLE;
               end
            end
         end
         default: begin
            next_st.adc_st = mcts_pkg::MCTS_ADC_IDLE;
         end
      endcase

      // write channel: address and data are taken in either order
      if (s_axi_awvalid && !st.aw_got && !st.bvalid) begin
         next_st.aw_got = 1'b1;
         next_st.aw_idx = s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && !st.w_got && !st.bvalid) begin
         next_st.w_got = 1'b1;
         next_st.w_data = s_axi_wdata[7:0];
         next_st.w_lane0 = s_axi_wstrb[0];
      end
      if (wr_fire) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = `MCTS_RESP_OKAY;
         case (st.aw_idx)
            `MCTS_IDX_MAIN: begin
               if (st.w_lane0) begin
                  next_st.main_cfg = st.w_data & `MCTS_MAIN_MASK;
               end
            end
            `MCTS_IDX_PERI: begin
               if (st.w_lane0) begin
                  next_st.peri_cfg = st.w_data & `MCTS_PERI_MASK;
               end
            end
            `MCTS_IDX_STAT: begin
               next_st.bresp = `MCTS_RESP_OKAY;
            end
            default: begin
               next_st.bresp = `MCTS_RESP_SLV;
            end
         endcase
      end else if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end

      // read channel: one read at a time, answer one cycle after the take
      if (rd_fire) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = `MCTS_RESP_OKAY;
         case (rd_idx)
            `MCTS_IDX_MAIN: begin
               next_st.rdata = st.main_cfg;
            end
            `MCTS_IDX_PERI: begin
               next_st.rdata = st.peri_cfg;
            end
            `MCTS_IDX_STAT: begin
               next_st.rdata = {2'h0, st.sys_lvl, st.main_lvl,
                                (st.adc_st == mcts_pkg::MCTS_ADC_RUN), sleep_mode,
                                st.xtal_osc_en, st.int_osc_en};
            end
            default: begin
               next_st.rdata = 8'h00;
               next_st.rresp = `MCTS_RESP_SLV;
            end
         endcase
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.main_cfg <= `MCTS_MAIN_RST;
         st.peri_cfg <= `MCTS_PERI_RST;
         st.int_osc_en <= 1'b1;
         st.xtal_osc_en <= 1'b1;
         st.adc_st <= mcts_pkg::MCTS_ADC_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign s_axi_awready = ~st.aw_got & ~st.bvalid;
   assign s_axi_wready  = ~st.w_got & ~st.bvalid;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = ~st.rvalid;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = {24'h000000, st.rdata};
   assign s_axi_rresp   = st.rresp;

   assign int_osc_en      = st.int_osc_en;
   assign xtal_osc_en     = st.xtal_osc_en;
   assign main_clock      = st.main_lvl;
   assign system_clock    = st.sys_lvl;
   assign cpu_cycle_clk   = ch_lvl[`MCTS_CH_INSTR];
   assign adc_sample_freq = ch_lvl[`MCTS_CH_ADC];
   assign adc_conv_busy   = (st.adc_st == mcts_pkg::MCTS_ADC_RUN);
   assign adc_conv_done   = st.adc_done;
   assign beeper_clk      = ch_lvl[`MCTS_CH_BEEP];
   assign doubler_clk     = ch_lvl[`MCTS_CH_PUMP];
   assign doubler_on      = doubler_sel;
   assign chopper_ctl     = ch_lvl[`MCTS_CH_CHOP];
   assign timer_lcd_clock = ch_lvl[`MCTS_CH_TICK];

endmodule : mcts_top
`default_nettype wire
